// [cfms_pkg.sv]
// Purpose: Shared constants, field layout and carrier types for the codec
//          filter and routing configuration register.
// Assumes: One 20 MHz clock; control words arrive already deframed.
// Notes:   Every offset, bit position and count lives here, with the register reset value; other reset levels are set where used.

// ===========================================================================
// Package
package cfms_pkg;

   // ========================================================================
   // Control address and word layout
   localparam int          ADDR_W          = 6;
   localparam int          WORD_W          = 16;
   localparam int          DELAY_W         = 6;
   localparam logic [5:0]  FILTER_CFG_ADDR = 6'h19;
   localparam logic [15:0] FILTER_CFG_RST  = 16'h0000;

   localparam int BIT_RESAMP   = 15;
   localparam int BIT_MIX      = 14;
   localparam int BIT_DAC2_FLT = 9;
   localparam int BIT_DAC1_FLT = 8;
   localparam int SRC_R_HI     = 7;
   localparam int SRC_R_LO     = 6;
   localparam int SRC_L_HI     = 5;
   localparam int SRC_L_LO     = 4;
   localparam int BIT_ADCR_FLT = 1;
   localparam int BIT_ADCL_FLT = 0;

   // Reserved positions, bits 13..10 and 3..2.
   localparam logic [15:0] RESERVED_MASK = 16'h3C0C;

   // ========================================================================
   // Source field codes
   localparam logic [1:0] SRC_CODE_ANALOG = 2'h0;
   localparam logic [1:0] SRC_CODE_RSVD   = 2'h1;
   localparam logic [1:0] SRC_CODE_DAC1   = 2'h2;
   localparam logic [1:0] SRC_CODE_DAC2   = 2'h3;

   // ========================================================================
   // Linear group delay bounds in sample periods
   localparam logic [5:0] DELAY_AUDIO  = 6'h0F;
   localparam logic [5:0] DELAY_MODEM  = 6'h13;
   localparam logic [5:0] DELAY_RESAMP = 6'h19;
   localparam logic [5:0] DELAY_NONE   = 6'h00;

   // ========================================================================
   // Synchroniser depth for pin inputs
   localparam int SYNC_STAGES = 2;

   // ========================================================================
   // Types
   typedef enum logic [1:0] {
      CFMS_FLT_AUDIO,
      CFMS_FLT_MODEM,
      CFMS_FLT_RESAMP,
      CFMS_FLT_OFF
   } cfms_filter_t;

   typedef enum logic [1:0] {
      CFMS_SRC_ANALOG,
      CFMS_SRC_DAC1,
      CFMS_SRC_DAC2
   } cfms_src_t;

   typedef struct packed {
      logic       resampler_filter_mode;
      logic       dac_pair_mix_enable;
      logic       second_dac_filter_sel;
      logic       first_dac_filter_sel;
      logic [1:0] right_adc_source_sel;
      logic [1:0] left_adc_source_sel;
      logic       right_adc_filter_sel;
      logic       left_adc_filter_sel;
   } cfms_cfg_t;

   typedef struct packed {
      logic dac1_down;
      logic dac2_down;
      logic adc_l_down;
      logic adc_r_down;
   } cfms_pd_t;

   typedef struct packed {
      cfms_filter_t     dac1_filter;
      cfms_filter_t     dac2_filter;
      cfms_filter_t     adc_l_filter;
      cfms_filter_t     adc_r_filter;
      logic             dac2_enabled;
      logic             dac2_modem_swing;
      logic             adc_l_wide_map;
      logic             adc_r_wide_map;
      logic             dac_mix;
      cfms_src_t        adc_l_src;
      cfms_src_t        adc_r_src;
      logic [5:0]       dac1_delay;
      logic [5:0]       dac2_delay;
      logic [5:0]       adc_l_delay;
      logic [5:0]       adc_r_delay;
   } cfms_route_t;

   // Rejected-field flags for the power-gated fields of the last write.
   typedef struct packed {
      logic resamp;
      logic mix;
      logic dac2_flt;
      logic dac1_flt;
      logic adcr_flt;
      logic adcl_flt;
   } cfms_reject_t;

   // ========================================================================
   // Word conversion
   function automatic cfms_cfg_t cfms_unpack(input logic [15:0] w);
      cfms_cfg_t c;
      c.resampler_filter_mode = w[BIT_RESAMP];
      c.dac_pair_mix_enable   = w[BIT_MIX];
      c.second_dac_filter_sel = w[BIT_DAC2_FLT];
      c.first_dac_filter_sel  = w[BIT_DAC1_FLT];
      c.right_adc_source_sel  = w[SRC_R_HI:SRC_R_LO];
      c.left_adc_source_sel   = w[SRC_L_HI:SRC_L_LO];
      c.right_adc_filter_sel  = w[BIT_ADCR_FLT];
      c.left_adc_filter_sel   = w[BIT_ADCL_FLT];
      return c;
   endfunction

   // Reserved bits always read back as zero.
   function automatic logic [15:0] cfms_pack(input cfms_cfg_t c);
      logic [15:0] w;
      w                    = 16'h0000;
      w[BIT_RESAMP]        = c.resampler_filter_mode;
      w[BIT_MIX]           = c.dac_pair_mix_enable;
      w[BIT_DAC2_FLT]      = c.second_dac_filter_sel;
      w[BIT_DAC1_FLT]      = c.first_dac_filter_sel;
      w[SRC_R_HI:SRC_R_LO] = c.right_adc_source_sel;
      w[SRC_L_HI:SRC_L_LO] = c.left_adc_source_sel;
      w[BIT_ADCR_FLT]      = c.right_adc_filter_sel;
      w[BIT_ADCL_FLT]      = c.left_adc_filter_sel;
      return w;
   endfunction

endpackage

// [cfms_sync.sv]
// Purpose: Multi-stage synchroniser for levels arriving from a pin.
// Assumes: Input is a slow level; glitches shorter than a cycle may vanish.
// Notes:   Only the next stage reads the first stage.
`timescale 1ns/10ps

// ===========================================================================
// Synchroniser
module cfms_sync #(
   parameter int   STAGES  = 2,
   parameter logic RST_VAL = 1'b0
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic din,
   output logic      dout
);

   logic [STAGES-1:0] chain_q;
   logic [STAGES-1:0] chain_d;

   // Fewer than two stages cannot settle a metastable first flop.
   if (STAGES < 2) begin : g_check
      $error("cfms_sync needs at least two stages.");
   end

   // Shift the pin level one stage per clock.
   always_comb begin
      chain_d = {chain_q[STAGES-2:0], din};
   end

   // Reset loads a constant only.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         chain_q <= {STAGES{RST_VAL}};
      end else begin
         chain_q <= chain_d;
      end
   end

   assign dout = chain_q[STAGES-1];

endmodule

// [cfms_route_decode.sv]
// Purpose: Turns the stored configuration into per-channel filter, swing,
//          mixing, source and group delay settings.
// Assumes: Pure combinational; the caller registers the result.
// Notes:   Reserved source code 01 is treated as the analog source.
`timescale 1ns/10ps

// ===========================================================================
// Decode
module cfms_route_decode (
   input  cfms_pkg::cfms_cfg_t   cfg,
   output cfms_pkg::cfms_route_t route
);

   // Filter choice for one channel given its own select bit.
   function automatic cfms_pkg::cfms_filter_t pick(input logic resamp,
                                                   input logic sel);
      if (resamp) begin
         return cfms_pkg::CFMS_FLT_RESAMP;
      end
      return sel ? cfms_pkg::CFMS_FLT_MODEM : cfms_pkg::CFMS_FLT_AUDIO;
   endfunction

   function automatic cfms_pkg::cfms_src_t src(input logic [1:0] code);
      case (code)
         cfms_pkg::SRC_CODE_DAC1: return cfms_pkg::CFMS_SRC_DAC1;
         cfms_pkg::SRC_CODE_DAC2: return cfms_pkg::CFMS_SRC_DAC2;
         default:                 return cfms_pkg::CFMS_SRC_ANALOG;
      endcase
   endfunction

   function automatic logic [5:0] dly(input cfms_pkg::cfms_filter_t f);
      case (f)
         cfms_pkg::CFMS_FLT_AUDIO:  return cfms_pkg::DELAY_AUDIO;
         cfms_pkg::CFMS_FLT_MODEM:  return cfms_pkg::DELAY_MODEM;
         cfms_pkg::CFMS_FLT_RESAMP: return cfms_pkg::DELAY_RESAMP;
         default:                   return cfms_pkg::DELAY_NONE;
      endcase
   endfunction

   // Per-channel decode of the stored fields.
   always_comb begin
      route.dac1_filter  = pick(cfg.resampler_filter_mode,
                                cfg.first_dac_filter_sel);
      route.adc_l_filter = pick(cfg.resampler_filter_mode,
                                cfg.left_adc_filter_sel);
      route.adc_r_filter = pick(cfg.resampler_filter_mode,
                                cfg.right_adc_filter_sel);
      route.dac2_enabled = !cfg.resampler_filter_mode;
      route.dac2_filter  = cfg.resampler_filter_mode ?
                           cfms_pkg::CFMS_FLT_OFF :
                           pick(1'b0, cfg.second_dac_filter_sel);
      route.dac2_modem_swing = !cfg.resampler_filter_mode &&
                               cfg.second_dac_filter_sel;
      route.adc_r_wide_map = !cfg.resampler_filter_mode &&
                             cfg.right_adc_filter_sel;
      route.adc_l_wide_map = !cfg.resampler_filter_mode &&
                             cfg.left_adc_filter_sel;
      route.dac_mix = cfg.dac_pair_mix_enable;
      route.adc_r_src = src(cfg.right_adc_source_sel);
      route.adc_l_src = src(cfg.left_adc_source_sel);
      route.dac1_delay = dly(route.dac1_filter);
      route.dac2_delay = dly(route.dac2_filter);
      route.adc_l_delay = dly(route.adc_l_filter);
      route.adc_r_delay = dly(route.adc_r_filter);
      if (route.adc_l_src != cfms_pkg::CFMS_SRC_ANALOG) begin
         route.adc_l_delay = {route.adc_l_delay[4:0], 1'b0};
      end
      if (route.adc_r_src != cfms_pkg::CFMS_SRC_ANALOG) begin
         route.adc_r_delay = {route.adc_r_delay[4:0], 1'b0};
      end
   end

endmodule

// [cfms_filter_mode_select.sv]
// Purpose: Filter and routing configuration register of the codec, written
//          over deframed control slots, with decoded mode outputs.
// Assumes: ctrl_* and frame_start come from the serial slot logic on clk;
//          the power-down pin is asynchronous and is synchronised here.
// Notes:   Decoded outputs follow the stored word by one clock.
`timescale 1ns/10ps

// Operation
// - Resampler mode overrides filters, drops second DAC
// - Resampler bit changes only with all down
// - Resampler mode alone never reroutes data
// - Mix bit sums DAC pairs after interpolation
// - Mix bit changes only with both DACs down
// - Second DAC filter bit picks filter, swing
// - Second DAC filter changes only when down
// - First DAC filter bit, gated by power-down
// - Right source: analog, first or second DAC
// - Left source: analog, first or second DAC
// - Right ADC filter and mapping, gated
// - Left ADC filter and mapping, gated
// - Reset value is all zeros
// - Clear and refuse writes while disabled
// - Loopback doubles ripple and group delay
// - Group delay bounds 15, 19, 25 samples
// - Prior contents sent in next slot 1
module cfms_filter_mode_select (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   chip_powerdown_pin_n,
   input  wire logic                   global_conversion_disable,
   input  cfms_pkg::cfms_pd_t          pd,
   input  wire logic                   ctrl_access,
   input  wire logic                   ctrl_write,
   input  wire logic [5:0]             ctrl_addr,
   input  wire logic [15:0]            ctrl_wdata,
   input  wire logic                   frame_start,
   output logic [15:0]                 cfg_word_q,
   output cfms_pkg::cfms_route_t       route_q,
   output logic                        slot1_valid_q,
   output logic [15:0]                 slot1_data_q,
   output cfms_pkg::cfms_reject_t      reject_q,
   output logic                        reserved_written_q
);

   // ========================================================================
   // Declarations
   localparam cfms_pkg::cfms_cfg_t CFG_RST =
      cfms_pkg::cfms_unpack(cfms_pkg::FILTER_CFG_RST);

   cfms_pkg::cfms_cfg_t    cfg_q;
   cfms_pkg::cfms_cfg_t    cfg_d;
   cfms_pkg::cfms_cfg_t    wr_cfg;
   cfms_pkg::cfms_route_t  route_d;
   cfms_pkg::cfms_route_t  route_c;
   cfms_pkg::cfms_reject_t reject_d;
   logic                   resv_d;
   logic                   pin_active_n;
   logic                   hold_clear;
   logic                   addr_hit;
   logic                   wr_hit;
   logic                   pend_q;
   logic                   pend_d;
   logic [15:0]            pend_data_q;
   logic [15:0]            pend_data_d;
   logic                   slot1_valid_d;
   logic [15:0]            slot1_data_d;
   logic [15:0]            cfg_word_d;

   // ========================================================================
   // Pin synchroniser
   // The pin resets to the low (powered down) level, so the register stays
   // cleared until two clean samples of a high pin have been seen.
   cfms_sync #(
      .STAGES  (cfms_pkg::SYNC_STAGES),
      .RST_VAL (1'b0)
   ) u_pwrdn_sync (
      .clk  (clk),
      .rst  (rst),
      .din  (chip_powerdown_pin_n),
      .dout (pin_active_n)
   );

   // ========================================================================
   // Decode
   cfms_route_decode u_decode (
      .cfg   (cfg_q),
      .route (route_c)
   );

   // ========================================================================
   // Access decode
   // Clear and refuse conditions.
   assign hold_clear = !pin_active_n || global_conversion_disable;
   assign addr_hit   = ctrl_access && (ctrl_addr == cfms_pkg::FILTER_CFG_ADDR);
   assign wr_hit     = addr_hit && ctrl_write;
   assign wr_cfg     = cfms_pkg::cfms_unpack(ctrl_wdata);

   // ========================================================================
   // Configuration register
   // Each power-gated field is updated on its own, so one blocked field never
   // costs the host the rest of the word.
   always_comb begin
      cfg_d    = cfg_q;
      reject_d = reject_q;
      resv_d   = reserved_written_q;
      if (hold_clear) begin
         cfg_d    = CFG_RST;
         reject_d = '0;
         resv_d   = 1'b0;
      end else if (wr_hit) begin
         reject_d = '0;
         resv_d = |(ctrl_wdata & cfms_pkg::RESERVED_MASK);
         cfg_d.right_adc_source_sel = wr_cfg.right_adc_source_sel;
         cfg_d.left_adc_source_sel  = wr_cfg.left_adc_source_sel;
         if (pd.dac1_down && pd.dac2_down && pd.adc_l_down &&
             pd.adc_r_down) begin
            cfg_d.resampler_filter_mode = wr_cfg.resampler_filter_mode;
         end else begin
            reject_d.resamp = wr_cfg.resampler_filter_mode !=
                              cfg_q.resampler_filter_mode;
         end
         if (pd.dac1_down && pd.dac2_down) begin
            cfg_d.dac_pair_mix_enable = wr_cfg.dac_pair_mix_enable;
         end else begin
            reject_d.mix = wr_cfg.dac_pair_mix_enable !=
                           cfg_q.dac_pair_mix_enable;
         end
         if (pd.dac2_down) begin
            cfg_d.second_dac_filter_sel = wr_cfg.second_dac_filter_sel;
         end else begin
            reject_d.dac2_flt = wr_cfg.second_dac_filter_sel !=
                                cfg_q.second_dac_filter_sel;
         end
         if (pd.dac1_down) begin
            cfg_d.first_dac_filter_sel = wr_cfg.first_dac_filter_sel;
         end else begin
            reject_d.dac1_flt = wr_cfg.first_dac_filter_sel !=
                                cfg_q.first_dac_filter_sel;
         end
         if (pd.adc_r_down) begin
            cfg_d.right_adc_filter_sel = wr_cfg.right_adc_filter_sel;
         end else begin
            reject_d.adcr_flt = wr_cfg.right_adc_filter_sel !=
                                cfg_q.right_adc_filter_sel;
         end
         if (pd.adc_l_down) begin
            cfg_d.left_adc_filter_sel = wr_cfg.left_adc_filter_sel;
         end else begin
            reject_d.adcl_flt = wr_cfg.left_adc_filter_sel !=
                                cfg_q.left_adc_filter_sel;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_q              <= CFG_RST;
         reject_q           <= '0;
         reserved_written_q <= 1'b0;
      end else begin
         cfg_q              <= cfg_d;
         reject_q           <= reject_d;
         reserved_written_q <= resv_d;
      end
   end

   // ========================================================================
   // Decoded outputs
   // Registering the decode keeps every output on a flop, at the cost of one
   // clock of lag behind the stored word.
   always_comb begin
      route_d    = route_c;
      cfg_word_d = cfms_pkg::cfms_pack(cfg_q);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         route_q    <= '0;
         cfg_word_q <= '0;
      end else begin
         route_q    <= route_d;
         cfg_word_q <= cfg_word_d;
      end
   end

   // ========================================================================
   // Slot 1 echo
   // An access latches the word as it stood before the access; the next
   // frame start moves it to the slot 1 outputs for that whole frame.  An
   // access in the same cycle as a frame start belongs to the next frame.
   always_comb begin
      pend_d        = pend_q;
      pend_data_d   = pend_data_q;
      slot1_valid_d = slot1_valid_q;
      slot1_data_d  = slot1_data_q;
      if (frame_start) begin
         slot1_valid_d = pend_q;
         slot1_data_d  = pend_q ? pend_data_q : 16'h0000;
         pend_d        = 1'b0;
      end
      if (addr_hit) begin
         pend_d      = 1'b1;
         pend_data_d = cfms_pkg::cfms_pack(cfg_q);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pend_q        <= 1'b0;
         pend_data_q   <= '0;
         slot1_valid_q <= 1'b0;
         slot1_data_q  <= '0;
      end else begin
         pend_q        <= pend_d;
         pend_data_q   <= pend_data_d;
         slot1_valid_q <= slot1_valid_d;
         slot1_data_q  <= slot1_data_d;
      end
   end

endmodule

// [cfms_chk.sv]
// Purpose: Port assertions for the filter and routing register.
// Assumes: One clock; rst is asynchronous and active high.
// Notes:   A write counts only after four samples of a high pin.
`timescale 1ns/10ps

// =====
// Checker
module cfms_chk (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              chip_powerdown_pin_n,
   input  wire logic              global_conversion_disable,
   input  cfms_pkg::cfms_pd_t     pd,
   input  wire logic              ctrl_access,
   input  wire logic              ctrl_write,
   input  wire logic [5:0]        ctrl_addr,
   input  wire logic [15:0]       ctrl_wdata,
   input  wire logic              frame_start,
   input  wire logic [15:0]       cfg_word_q,
   input  cfms_pkg::cfms_route_t  route_q,
   input  wire logic              slot1_valid_q,
   input  wire logic [15:0]       slot1_data_q
);
   localparam logic [15:0] M = cfms_pkg::RESERVED_MASK;
   // Access decode; the pin is synchronised inside, so it needs margin.
   wire acc19 = ctrl_access && ctrl_addr == cfms_pkg::FILTER_CFG_ADDR;
   wire wr_ok = acc19 && ctrl_write && !global_conversion_disable;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_live;
      chip_powerdown_pin_n [*4] ##0 wr_ok;
   endsequence
   property p_clr;
      global_conversion_disable |-> ##2 cfg_word_q == 16'h0000;
   endproperty
   a_clr: assert property (p_clr) else $error("word not cleared");
   property p_all;
      s_live ##0 (&pd) |-> ##2 cfg_word_q == ($past(ctrl_wdata, 2) & ~M);
   endproperty
   a_all: assert property (p_all) else $error("write lost");
   property p_mix;
      s_live ##0 !(pd.dac1_down && pd.dac2_down) |->
         ##2 $stable(cfg_word_q[14]);
   endproperty
   a_mix: assert property (p_mix) else $error("mix bit moved");
   property p_rsm;
      s_live ##0 !(&pd) |-> ##2 $stable(cfg_word_q[15]);
   endproperty
   a_rsm: assert property (p_rsm) else $error("resampler moved");
   property p_src;
      s_live |-> ##2 cfg_word_q[7:4] == $past(ctrl_wdata[7:4], 2);
   endproperty
   a_src: assert property (p_src) else $error("source lost");
   property p_ovr;
      cfg_word_q[15] |-> !route_q.dac2_enabled &&
         route_q.adc_l_filter == cfms_pkg::CFMS_FLT_RESAMP;
   endproperty
   a_ovr: assert property (p_ovr) else $error("no override");
   property p_dly;
      (cfg_word_q & 16'h8031) == 16'h0021 |->
         route_q.adc_l_delay == 6'h26;
   endproperty
   a_dly: assert property (p_dly) else $error("delay not doubled");
   property p_echo;
      logic [15:0] v;
      (acc19 && !frame_start) ##1 (!acc19 && !frame_start, v = cfg_word_q)
         ##1 (frame_start && !acc19) |=> slot1_valid_q && slot1_data_q == v;
   endproperty
   a_echo: assert property (p_echo) else $error("bad echo");
endmodule

bind cfms_filter_mode_select cfms_chk chk (.clk, .rst,
   .chip_powerdown_pin_n, .global_conversion_disable, .pd, .ctrl_access,
   .ctrl_write, .ctrl_addr, .ctrl_wdata, .frame_start, .cfg_word_q,
   .route_q, .slot1_valid_q, .slot1_data_q);

// [cfms_host.sv]
// Purpose: Host model that issues control slot accesses and frames.
// Assumes: Called from the bench; drives on the falling edge.
// Notes:   Idle lines show the inverse of their last value.
`timescale 1ns/10ps

// =====
// Host
module cfms_host (
   input  wire logic   clk,
   output logic        ctrl_access,
   output logic        ctrl_write,
   output logic [5:0]  ctrl_addr,
   output logic [15:0] ctrl_wdata,
   output logic        frame_start
);
   // Quiet lines at time zero.
   initial begin
      ctrl_access = 1'b0;
      ctrl_write = 1'b0;
      ctrl_addr = 6'h2A;
      ctrl_wdata = 16'h5A5A;
      frame_start = 1'b0;
   end
   // Reserved bits zeroed unless keep is set
   task automatic acc(input logic wr, input logic [5:0] a,
                      input logic [15:0] d, input logic keep);
      @(negedge clk);
      ctrl_access = 1'b1;
      ctrl_write = wr;
      ctrl_addr = a;
      ctrl_wdata = keep ? d : d & ~cfms_pkg::RESERVED_MASK;
      @(negedge clk);
      ctrl_access = 1'b0;
      ctrl_write = ~wr;
      ctrl_addr = ~a;
      ctrl_wdata = ~ctrl_wdata;
   endtask
   // One frame start, a cycle clear of any access.
   task automatic frame();
      @(negedge clk);
      frame_start = 1'b1;
      @(negedge clk);
      frame_start = 1'b0;
   endtask
endmodule

// [tb_top.sv]
// Purpose: Self-checking bench for the filter and routing register.
// Assumes: Inputs change on the falling edge of a 50 ns clock.
// Notes:   Gated writes run under random power-down masks.
`timescale 1ns/10ps

`define CHK(nm, e, s) begin \
   samples_checked++; \
   if ((s) !== (e)) begin \
      n_mismatch++; \
      $display("BAD %s exp %h got %h", nm, e, s); \
   end \
end

// =====
// Bench
module tb_top;
   logic                   clk, rst, chip_powerdown_pin_n, frame_start;
   logic                   global_conversion_disable, ctrl_access;
   logic                   ctrl_write, slot1_valid_q, reserved_written_q;
   logic [5:0]             ctrl_addr;
   logic [15:0]            ctrl_wdata, cfg_word_q, slot1_data_q;
   logic [15:0]            lfsr, w, old;
   cfms_pkg::cfms_pd_t     pd;
   cfms_pkg::cfms_route_t  route_q;
   cfms_pkg::cfms_reject_t reject_q;
   int                     n_mismatch, samples_checked;
   logic [15:0]            crn [6] = '{16'hFFFF, 16'h0021, 16'h0050,
                                       16'h00E0, 16'h8020, 16'h0000};
   wire  [17:0]            rt = {route_q.adc_l_filter, route_q.adc_l_src,
      route_q.adc_l_delay, route_q.dac_mix, route_q.dac2_enabled,
      route_q.dac1_filter, route_q.adc_r_src, route_q.dac2_modem_swing,
      route_q.adc_r_wide_map};

   cfms_host host (.clk, .ctrl_access, .ctrl_write, .ctrl_addr,
      .ctrl_wdata, .frame_start);
   cfms_filter_mode_select dut (.clk, .rst, .chip_powerdown_pin_n,
      .global_conversion_disable, .pd, .ctrl_access, .ctrl_write,
      .ctrl_addr, .ctrl_wdata, .frame_start, .cfg_word_q, .route_q,
      .slot1_valid_q, .slot1_data_q, .reject_q, .reserved_written_q);

   // Random source, fixed start so runs repeat.
   function automatic logic [15:0] step();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr;
   endfunction
   // Stored word after a write; the source fields always move, any other field only if its channels are down.
   function automatic logic [15:0] nxt(logic [15:0] o, d, logic [3:0] p);
      logic [15:0] g;
      g = 16'h00F0;
      g[15] = &p;
      g[14] = p[3] && p[2];
      g[9] = p[2];
      g[8] = p[3];
      g[1] = p[0];
      g[0] = p[1];
      return (o & ~g) | (d & g);
   endfunction
   // Left ADC decode, mix, second DAC on, first DAC filter, right source,
   // second DAC swing and right input mapping.
   function automatic logic [17:0] rte(logic [15:0] c);
      logic [1:0] f;
      logic [1:0] s;
      logic [5:0] d;
      f = c[15] ? 2'h2 : {1'b0, c[0]};
      s = c[5] ? {c[4], ~c[4]} : 2'h0;
      d = c[15] ? 6'h19 : (c[0] ? 6'h13 : 6'h0F);
      if (c[5]) d = d << 1;
      return {f, s, d, c[14], ~c[15], c[15] ? 2'h2 : {1'b0, c[8]},
              c[7] ? {c[6], ~c[6]} : 2'h0, ~c[15] & c[9], ~c[15] & c[1]};
   endfunction

   task automatic print_verdict();
      $display("mismatches %0d of %0d checks", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Write, then check word, flags and decode
   task automatic wr(input logic [15:0] d, input logic keep);
      logic [15:0] e;
      logic [15:0] r;
      e = nxt(old, d, pd);
      r = (old ^ d) & ~(old ^ e) & 16'hC303;
      host.acc(1'b1, 6'h19, d, keep);
      repeat (2) @(negedge clk);
      `CHK("word", e, cfg_word_q)
      `CHK("reject", {r[15:14], r[9:8], r[1:0]}, reject_q)
      `CHK("rsvd", keep && |(d & 16'h3C0C), reserved_written_q)
      `CHK("route", rte(e), rt)
      old = e;
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Watchdog against a hung run.
   initial begin
      #1000000;
      n_mismatch++;
      print_verdict();
   end

   initial begin
      rst = 1'b1;
      chip_powerdown_pin_n = 1'b1;
      global_conversion_disable = 1'b0;
      pd = 4'hF;
      lfsr = 16'h7628;
      old = 16'h0000;
      n_mismatch = 0;
      samples_checked = 0;
      repeat (12) @(negedge clk);
      rst = 1'b0;
      `CHK("reset", 16'h0000, cfg_word_q)
      repeat (4) @(negedge clk);
      // Corner words with all channels down, then random masks and data.
      for (int i = 0; i < 70; i++) begin
         w = step();
         if (i >= 6) pd = w[3:0];
         wr((i < 6) ? crn[i] : step(), i == 0);
         host.acc(1'b1, 6'h1A, ~w, 1'b0);
      end
      // Read and write both echo the prior word
      pd = 4'hF;
      for (int k = 0; k < 2; k++) begin
         host.acc(k[0], 6'h19, 16'h0030, 1'b0);
         host.frame();
         `CHK("echo", {1'b1, old}, {slot1_valid_q, slot1_data_q})
         host.frame();
         `CHK("echo end", 1'b0, slot1_valid_q)
         if (k == 1) old = 16'h0030;
      end
      // Disable bit, then pin: clear and lock out writes
      for (int k = 0; k < 2; k++) begin
         wr(16'h0011, 1'b0);
         if (k == 1) chip_powerdown_pin_n = 1'b0;
         else global_conversion_disable = 1'b1;
         repeat (5) @(negedge clk);
         host.acc(1'b1, 6'h19, 16'h4321, 1'b0);
         repeat (2) @(negedge clk);
         `CHK("cleared", 16'h0000, cfg_word_q)
         chip_powerdown_pin_n = 1'b1;
         global_conversion_disable = 1'b0;
         old = 16'h0000;
         repeat (4) @(negedge clk);
      end
      // Reset in mid-run clears a written word
      wr(16'h0011, 1'b0);
      rst = 1'b1;
      @(negedge clk);
      rst = 1'b0;
      old = 16'h0000;
      `CHK("reset again", 16'h0000, cfg_word_q)
      repeat (4) @(negedge clk);
      wr(16'h0022, 1'b0);
      print_verdict();
   end
endmodule
